// >>> io_port_defines.vh
// register offsets, reset values and mode codes for the i/o port block
`ifndef IO_PORT_DEFINES_VH
`define IO_PORT_DEFINES_VH

// writable configuration and data registers
`define OFS_CTRL_A    8'h00
`define OFS_CTRL_B    8'h01
`define OFS_DIR_A     8'h02
`define OFS_DIR_B     8'h03
`define OFS_DIR_C     8'h04
`define OFS_DIR_D     8'h05
`define OFS_DOUT_A    8'h06
`define OFS_DOUT_B    8'h07
`define OFS_DOUT_C    8'h08
`define OFS_DOUT_D    8'h09
`define OFS_MMAP      8'h0A

// read-only state
`define OFS_DIN_A     8'h10
`define OFS_DIN_B     8'h11
`define OFS_DIN_C     8'h12
`define OFS_DIN_D     8'h13
`define OFS_IMC_A     8'h14
`define OFS_IMC_B     8'h15
`define OFS_IMC_C     8'h16
`define OFS_ENOUT_A   8'h18
`define OFS_ENOUT_B   8'h19
`define OFS_ENOUT_C   8'h1A
`define OFS_ENOUT_D   8'h1B

`define CFG_RESET     8'h00
`define PERIPH_BIT    7

// host bus types for address out pin mapping
`define BUS_MUX8      2'h0
`define BUS_PAGE      2'h1
`define BUS_MUX16_8   2'h2
`define BUS_NONMUX8   2'h3

// input macrocell modes, two bits per pin
`define IMC_DIRECT    2'h0
`define IMC_LATCH     2'h1
`define IMC_REG       2'h2

`endif

// >>> io_port_mode_logic.v
// per-pin mode logic and register file for four programmable i/o ports
`timescale 1ns/10ps
`include "io_port_defines.vh"
// Contract
// - pin driver enabled by output-enable product term OR direction bit
// - without product term or pld output, direction bit alone decides
// - host writes config and output registers and reads them back
// - ports a, b, c input macrocells: latch, register or direct
// - macrocells clocked by address strobe or a pld product term
// - macrocell outputs feed pld input bus and are host readable
// - pld, data port, address in modes fixed at build; peripheral mode set at run time
// - control bit zero gives host i/o mode, direction by bit or term
// - host i/o output drives data-out; input read via data-in path
// - ports c, d have no control register, default host i/o
// - pld output three-stated by product term or cleared direction
// - address out drives when enable active or direction and control one
// - non-multiplexed 8-bit host puts a7-a0 on port b
// - address out pin mapping depends on host bus type
// - address inputs latched in macrocells by the address strobe
// - data port mode disables general i/o on port a
// - bit 7 of memory map control enables port a peripheral buffer
// - peripheral buffer three-stated unless a peripheral select active
// - jtag on port c enabled by select, configuration or enable signal
// - mode availability restricted per port
// - control one selects address out; config registers reset to 00h
// - direction one is output, zero input; all inputs after reset
module io_port_mode_logic #(
  parameter [7:0] PLD_OUT_A    = 8'h00,
  parameter [7:0] PLD_OUT_B    = 8'h00,
  parameter [7:0] PLD_OUT_C    = 8'h00,
  parameter [2:0] PLD_OUT_D    = 3'h0,
  parameter [2:0] ECS_D        = 3'h0,
  parameter       DATA_PORT    = 1'b0,
  parameter [1:0] BUS_TYPE     = 2'h0,
  parameter [15:0] IMC_MODE_A  = 16'h0000,
  parameter [15:0] IMC_MODE_B  = 16'h0000,
  parameter [15:0] IMC_MODE_C  = 16'h0000,
  parameter [7:0] IMC_PTCLK_A  = 8'h00,
  parameter [7:0] IMC_PTCLK_B  = 8'h00,
  parameter [7:0] IMC_PTCLK_C  = 8'h00,
  parameter       JTAG_CFG     = 1'b0,
  parameter [7:0] JTAG_PINS    = 8'h00
) (
  input  wire        clk,
  input  wire        rstn,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // pins
  input  wire [7:0]  pin_a_i,
  output reg  [7:0]  pin_a_o,
  output reg  [7:0]  pin_a_oe,
  input  wire [7:0]  pin_b_i,
  output reg  [7:0]  pin_b_o,
  output reg  [7:0]  pin_b_oe,
  input  wire [7:0]  pin_c_i,
  output reg  [7:0]  pin_c_o,
  output reg  [7:0]  pin_c_oe,
  input  wire [2:0]  pin_d_i,
  output reg  [2:0]  pin_d_o,
  output reg  [2:0]  pin_d_oe,
  input  wire        strobe_pin,
  // host bus side
  input  wire [15:0] host_addr,
  input  wire [7:0]  bus_dout,
  input  wire        bus_read,
  input  wire        bus_write,
  output reg  [7:0]  bus_din,
  // logic array side
  input  wire [7:0]  pld_oe_a,
  input  wire [7:0]  pld_oe_b,
  input  wire [7:0]  pld_oe_c,
  input  wire [2:0]  pld_oe_d,
  input  wire [7:0]  pld_out_a,
  input  wire [7:0]  pld_out_b,
  input  wire [7:0]  pld_out_c,
  input  wire [2:0]  pld_out_d,
  input  wire [2:0]  ecs_d,
  input  wire        imc_pt_clk_a,
  input  wire        imc_pt_clk_b,
  input  wire        imc_pt_clk_c,
  output wire [7:0]  pld_in_a,
  output wire [7:0]  pld_in_b,
  output wire [7:0]  pld_in_c,
  output wire [2:0]  pld_in_d,
  input  wire        periph_select_a,
  input  wire        periph_select_b,
  // jtag sharing on port c
  input  wire        jtag_pin_select,
  input  wire        jtag_enable,
  input  wire [7:0]  jtag_o,
  input  wire [7:0]  jtag_oe,
  output wire        jtag_active,
  output wire [7:0]  jtag_i
);

  reg  [7:0]  ctrl_a_q;
  reg  [7:0]  ctrl_b_q;
  reg  [7:0]  dir_a_q;
  reg  [7:0]  dir_b_q;
  reg  [7:0]  dir_c_q;
  reg  [2:0]  dir_d_q;
  reg  [7:0]  dout_a_q;
  reg  [7:0]  dout_b_q;
  reg  [7:0]  dout_c_q;
  reg  [2:0]  dout_d_q;
  reg  [7:0]  mmap_q;

  // two-stage synchronisers on every pin input
  reg  [7:0]  a_m_q;
  reg  [7:0]  a_s_q;
  reg  [7:0]  b_m_q;
  reg  [7:0]  b_s_q;
  reg  [7:0]  c_m_q;
  reg  [7:0]  c_s_q;
  reg  [2:0]  d_m_q;
  reg  [2:0]  d_s_q;
  reg         stb_m_q;
  reg         stb_s_q;
  reg         stb_p_q;

  reg  [15:0] la_q;
  reg         pta_p_q;
  reg         ptb_p_q;
  reg         ptc_p_q;

  wire [7:0]  imc_a;
  wire [7:0]  imc_b;
  wire [7:0]  imc_c;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_m_q   <= 8'h00;
      a_s_q   <= 8'h00;
      b_m_q   <= 8'h00;
      b_s_q   <= 8'h00;
      c_m_q   <= 8'h00;
      c_s_q   <= 8'h00;
      d_m_q   <= 3'h0;
      d_s_q   <= 3'h0;
      stb_m_q <= 1'b0;
      stb_s_q <= 1'b0;
      stb_p_q <= 1'b0;
      pta_p_q <= 1'b0;
      ptb_p_q <= 1'b0;
      ptc_p_q <= 1'b0;
    end else begin
      a_m_q   <= pin_a_i;
      a_s_q   <= a_m_q;
      b_m_q   <= pin_b_i;
      b_s_q   <= b_m_q;
      c_m_q   <= pin_c_i;
      c_s_q   <= c_m_q;
      d_m_q   <= pin_d_i;
      d_s_q   <= d_m_q;
      stb_m_q <= strobe_pin;
      stb_s_q <= stb_m_q;
      stb_p_q <= stb_s_q;
      pta_p_q <= imc_pt_clk_a;
      ptb_p_q <= imc_pt_clk_b;
      ptc_p_q <= imc_pt_clk_c;
    end
  end

  // address latch follows the host address while the strobe is high
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      la_q <= 16'h0000;
    else if (stb_s_q)
      la_q <= host_addr;
  end

  // input macrocells, ports a to c
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_imc
      reg  qa;
      reg  qb;
      reg  qc;
      wire lva = IMC_PTCLK_A[i] ? imc_pt_clk_a : stb_s_q;
      wire lvb = IMC_PTCLK_B[i] ? imc_pt_clk_b : stb_s_q;
      wire lvc = IMC_PTCLK_C[i] ? imc_pt_clk_c : stb_s_q;
      wire rea = IMC_PTCLK_A[i] ? imc_pt_clk_a & ~pta_p_q
                                : stb_s_q & ~stb_p_q;
      wire reb = IMC_PTCLK_B[i] ? imc_pt_clk_b & ~ptb_p_q
                                : stb_s_q & ~stb_p_q;
      wire rec = IMC_PTCLK_C[i] ? imc_pt_clk_c & ~ptc_p_q
                                : stb_s_q & ~stb_p_q;
      wire [1:0] ma = IMC_MODE_A[2*i+1:2*i];
      wire [1:0] mb = IMC_MODE_B[2*i+1:2*i];
      wire [1:0] mc = IMC_MODE_C[2*i+1:2*i];
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          qa <= 1'b0;
          qb <= 1'b0;
          qc <= 1'b0;
        end else begin
          // latch is transparent while its clock level is high
          if ((ma == `IMC_LATCH && lva) || (ma == `IMC_REG && rea))
            qa <= a_s_q[i];
          if ((mb == `IMC_LATCH && lvb) || (mb == `IMC_REG && reb))
            qb <= b_s_q[i];
          if ((mc == `IMC_LATCH && lvc) || (mc == `IMC_REG && rec))
            qc <= c_s_q[i];
        end
      end
      assign imc_a[i] = (ma == `IMC_DIRECT) ? a_s_q[i] : qa;
      assign imc_b[i] = (mb == `IMC_DIRECT) ? b_s_q[i] : qb;
      assign imc_c[i] = (mc == `IMC_DIRECT) ? c_s_q[i] : qc;
    end
  endgenerate

  // port d has no macrocell; its inputs reach the array directly
  assign pld_in_a = imc_a;
  assign pld_in_b = imc_b;
  assign pld_in_c = imc_c;
  assign pld_in_d = d_s_q;

  // mode decode
  wire periph_en = mmap_q[`PERIPH_BIT] & ~DATA_PORT;
  wire psel_any  = periph_select_a | periph_select_b;
  assign jtag_active = jtag_pin_select | JTAG_CFG | jtag_enable;
  wire [7:0] jmask = jtag_active ? JTAG_PINS : 8'h00;
  assign jtag_i = c_s_q & JTAG_PINS;

  // address out mapping by host bus type
  reg  [7:0] addr_a;
  reg  [7:0] addr_b;
  always @* begin
    case (BUS_TYPE)
      `BUS_MUX8: begin
        addr_a = la_q[7:0];
        addr_b = la_q[7:0];
      end
      `BUS_PAGE: begin
        addr_a = 8'h00;
        addr_b = la_q[15:8];
      end
      `BUS_MUX16_8: begin
        addr_a = {la_q[7:4], 4'h0};
        addr_b = {4'h0, la_q[11:8]};
      end
      `BUS_NONMUX8: begin
        // no strobe on this bus, so the live address is used
        addr_a = 8'h00;
        addr_b = host_addr[7:0];
      end
      default: begin
        addr_a = 8'h00;
        addr_b = 8'h00;
      end
    endcase
  end

  // output multiplexers and driver enables
  reg  [7:0] a_src;
  reg  [7:0] a_en;
  reg  [7:0] b_src;
  reg  [7:0] b_en;
  reg  [7:0] c_src;
  reg  [7:0] c_en;
  reg  [2:0] d_src;
  reg  [2:0] d_en;
  always @* begin
    // ordinary pins: one source per pin, enable is an or of two terms
    a_src = (PLD_OUT_A & pld_out_a)
          | (~PLD_OUT_A & ctrl_a_q & addr_a)
          | (~PLD_OUT_A & ~ctrl_a_q & dout_a_q);
    a_en  = dir_a_q | pld_oe_a;
    if (DATA_PORT) begin
      // port a is the host data bus; general i/o has no say
      a_src = bus_dout;
      a_en  = {8{bus_read}};
    end else if (periph_en) begin
      a_src = bus_dout;
      a_en  = {8{psel_any & bus_write}};
    end
    b_src = (PLD_OUT_B & pld_out_b)
          | (~PLD_OUT_B & ctrl_b_q & addr_b)
          | (~PLD_OUT_B & ~ctrl_b_q & dout_b_q);
    b_en  = dir_b_q | pld_oe_b;
    // ports c and d have no control bits: host i/o unless a pld, jtag (port c) or ecs (port d) output
    c_src = (jmask & jtag_o)
          | (~jmask & PLD_OUT_C & pld_out_c)
          | (~jmask & ~PLD_OUT_C & dout_c_q);
    c_en  = (jmask & jtag_oe) | (~jmask & (dir_c_q | pld_oe_c));
    d_src = (ECS_D & ecs_d)
          | (~ECS_D & PLD_OUT_D & pld_out_d)
          | (~ECS_D & ~PLD_OUT_D & dout_d_q);
    d_en  = dir_d_q | pld_oe_d;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_o  <= 8'h00;
      pin_a_oe <= 8'h00;
      pin_b_o  <= 8'h00;
      pin_b_oe <= 8'h00;
      pin_c_o  <= 8'h00;
      pin_c_oe <= 8'h00;
      pin_d_o  <= 3'h0;
      pin_d_oe <= 3'h0;
      bus_din  <= 8'h00;
    end else begin
      pin_a_o  <= a_src;
      pin_a_oe <= a_en;
      pin_b_o  <= b_src;
      pin_b_oe <= b_en;
      pin_c_o  <= c_src;
      pin_c_oe <= c_en;
      pin_d_o  <= d_src;
      pin_d_oe <= d_en;
      // buffer opens toward the host on a selected read, or always in data port mode
      bus_din  <= (DATA_PORT | (periph_en & psel_any & bus_read))
                  ? a_s_q : 8'h00;
    end
  end

  // register writes; build-time modes are parameters, not here
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_q <= `CFG_RESET;
      ctrl_b_q <= `CFG_RESET;
      dir_a_q  <= `CFG_RESET;
      dir_b_q  <= `CFG_RESET;
      dir_c_q  <= `CFG_RESET;
      dir_d_q  <= 3'h0;
      dout_a_q <= `CFG_RESET;
      dout_b_q <= `CFG_RESET;
      dout_c_q <= `CFG_RESET;
      dout_d_q <= 3'h0;
      mmap_q   <= `CFG_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CTRL_A: ctrl_a_q <= reg_wdata;
        `OFS_CTRL_B: ctrl_b_q <= reg_wdata;
        `OFS_DIR_A:  dir_a_q  <= reg_wdata;
        `OFS_DIR_B:  dir_b_q  <= reg_wdata;
        `OFS_DIR_C:  dir_c_q  <= reg_wdata;
        `OFS_DIR_D:  dir_d_q  <= reg_wdata[2:0];
        `OFS_DOUT_A: dout_a_q <= reg_wdata;
        `OFS_DOUT_B: dout_b_q <= reg_wdata;
        `OFS_DOUT_C: dout_c_q <= reg_wdata;
        `OFS_DOUT_D: dout_d_q <= reg_wdata[2:0];
        `OFS_MMAP:   mmap_q   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // readback path; unmapped addresses and idle cycles read zero
  reg  [7:0] rd_d;
  always @* begin
    case (reg_addr)
      `OFS_CTRL_A:  rd_d = ctrl_a_q;
      `OFS_CTRL_B:  rd_d = ctrl_b_q;
      `OFS_DIR_A:   rd_d = dir_a_q;
      `OFS_DIR_B:   rd_d = dir_b_q;
      `OFS_DIR_C:   rd_d = dir_c_q;
      `OFS_DIR_D:   rd_d = {5'h00, dir_d_q};
      `OFS_DOUT_A:  rd_d = dout_a_q;
      `OFS_DOUT_B:  rd_d = dout_b_q;
      `OFS_DOUT_C:  rd_d = dout_c_q;
      `OFS_DOUT_D:  rd_d = {5'h00, dout_d_q};
      `OFS_MMAP:    rd_d = mmap_q;
      `OFS_DIN_A:   rd_d = a_s_q;
      `OFS_DIN_B:   rd_d = b_s_q;
      `OFS_DIN_C:   rd_d = c_s_q;
      `OFS_DIN_D:   rd_d = {5'h00, d_s_q};
      `OFS_IMC_A:   rd_d = imc_a;
      `OFS_IMC_B:   rd_d = imc_b;
      `OFS_IMC_C:   rd_d = imc_c;
      `OFS_ENOUT_A: rd_d = pin_a_oe;
      `OFS_ENOUT_B: rd_d = pin_b_oe;
      `OFS_ENOUT_C: rd_d = pin_c_oe;
      `OFS_ENOUT_D: rd_d = {5'h00, pin_d_oe};
      default:      rd_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_d : 8'h00;
  end

endmodule

// >>> io_port_sva.sv
// assertion checker for the i/o port mode block
`timescale 1ns/10ps
module io_port_sva #(
  parameter [15:0] IMC_MODE_A = 16'h0000,
  parameter [15:0] IMC_MODE_C = 16'h0000,
  parameter        DATA_PORT  = 1'b0,
  parameter        JTAG_CFG   = 1'b0
) (
  input wire       clk,
  input wire       rstn,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] pin_a_i,
  input wire [7:0] pin_a_oe,
  input wire [7:0] pin_b_oe,
  input wire [7:0] pin_c_oe,
  input wire [2:0] pin_d_i,
  input wire [2:0] pin_d_oe,
  input wire [7:0] pld_oe_b,
  input wire [7:0] pld_oe_c,
  input wire       imc_pt_clk_c,
  input wire [7:0] pld_in_a,
  input wire [7:0] pld_in_c,
  input wire [2:0] pld_in_d,
  input wire       periph_select_a,
  input wire       periph_select_b,
  input wire [7:0] bus_din,
  input wire       jtag_pin_select,
  input wire       jtag_enable,
  input wire       jtag_active
);
  reg [1:0] run_q;
  // edges since release, so $past never looks into reset
  always @(posedge clk or negedge rstn)
    if (!rstn) run_q <= 2'h0;
    else if (run_q != 2'h3) run_q <= run_q + 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence pt_clk_quiet;
    !imc_pt_clk_c [*3];
  endsequence
  a_oe_or_b: assert property (run_q != 2'h0 |->
    (pin_b_oe & $past(pld_oe_b)) == $past(pld_oe_b)) else $error("b oe");
  a_oe_or_c: assert property (run_q != 2'h0 |->
    (pin_c_oe & $past(pld_oe_c)) == $past(pld_oe_c)) else $error("c oe");
  a_reset_inputs: assert property (run_q == 2'h0 |->
    (pin_a_oe | pin_b_oe | pin_c_oe) == 8'h00 && pin_d_oe == 3'h0)
    else $error("driver on after reset");
  a_read_window: assert property (run_q != 2'h0 && !$past(reg_rd) |->
    reg_rdata == 8'h00) else $error("read data outside window");
  a_jtag_any: assert property (
    jtag_active == (jtag_pin_select || jtag_enable || JTAG_CFG))
    else $error("jtag enable");
  a_sync_d: assert property (run_q > 2'h1 |->
    pld_in_d == $past(pin_d_i, 2)) else $error("port d input path");
  a_imc_direct: assert property (IMC_MODE_A == 16'h0000 &&
    run_q > 2'h1 |-> pld_in_a == $past(pin_a_i, 2)) else $error("direct");
  a_imc_hold: assert property (IMC_MODE_C == 16'hAAAA &&
    run_q == 2'h3 ##0 pt_clk_quiet |=> $stable(pld_in_c))
    else $error("register moved without clock");
  a_din_quiet: assert property (!DATA_PORT && run_q != 2'h0 &&
    !$past(periph_select_a) && !$past(periph_select_b) |->
    bus_din == 8'h00) else $error("buffer open without select");
endmodule

bind io_port_mode_logic io_port_sva #(.IMC_MODE_A(IMC_MODE_A),
  .IMC_MODE_C(IMC_MODE_C), .DATA_PORT(DATA_PORT), .JTAG_CFG(JTAG_CFG))
  chk (.clk, .rstn, .reg_rd, .reg_rdata, .pin_a_i, .pin_a_oe, .pin_b_oe,
  .pin_c_oe, .pin_d_i, .pin_d_oe, .pld_oe_b, .pld_oe_c, .imc_pt_clk_c,
  .pld_in_a, .pld_in_c, .pld_in_d, .periph_select_a, .periph_select_b,
  .bus_din, .jtag_pin_select, .jtag_enable, .jtag_active);

// >>> pin_partner.sv
// far-side device and wire resolution for one port
`timescale 1ns/10ps
module pin_partner #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire [W-1:0] o,
  input  wire [W-1:0] oe,
  input  wire [W-1:0] ext_val,
  input  wire [W-1:0] ext_en,
  output wire [W-1:0] i,
  output wire         clash
);
  reg [W-1:0] float_q = {W{1'b0}};
  // undriven lines toggle so a stale level never reads as valid
  always @(posedge clk) float_q <= ~float_q;
  assign i = (oe & o) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & float_q);
  assign clash = |(oe & ext_en);
endmodule

// >>> testbench.sv
// self-checking testbench for the i/o port mode block
`timescale 1ns/10ps
`include "io_port_defines.vh"
module testbench;
  reg        clk, rstn, reg_wr, reg_rd, strobe_pin, bus_read, bus_write;
  reg  [7:0] reg_addr, reg_wdata, bus_dout, jtag_o, jtag_oe;
  reg  [7:0] pld_oe_a, pld_oe_b, pld_oe_c, pld_out_a, pld_out_b, pld_out_c;
  reg  [2:0] pld_oe_d, pld_out_d, ecs_d;
  reg [15:0] host_addr;
  reg        imc_pt_clk_a, imc_pt_clk_b, imc_pt_clk_c, jtag_pin_select;
  reg        periph_select_a, periph_select_b, jtag_enable;
  reg  [7:0] ext_a, ext_b, ext_c, en_a, en_b, en_c, d, q, t, e, v;
  reg  [2:0] ext_d, en_d;
  wire [7:0] reg_rdata, bus_din, pld_in_a, pld_in_b, pld_in_c, jtag_i;
  wire [7:0] pin_a_i, pin_a_o, pin_a_oe, pin_b_i, pin_b_o, pin_b_oe;
  wire [7:0] pin_c_i, pin_c_o, pin_c_oe;
  wire [2:0] pin_d_i, pin_d_o, pin_d_oe, pld_in_d;
  wire [3:0] clash;
  wire       jtag_active;
  integer    i, seed, fail_count, cmp_count;

  io_port_mode_logic #(.IMC_MODE_B(16'h5555), .IMC_MODE_C(16'hAAAA),
    .IMC_PTCLK_C(8'hFF), .JTAG_PINS(8'h0F)) dut (.clk, .rstn, .reg_addr,
    .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pin_a_i, .pin_a_o, .pin_a_oe, .pin_b_i, .pin_b_o,
    .pin_b_oe, .pin_c_i, .pin_c_o, .pin_c_oe, .pin_d_i, .pin_d_o, .pin_d_oe,
    .strobe_pin, .host_addr, .bus_dout, .bus_read, .bus_write, .bus_din,
    .pld_oe_a, .pld_oe_b, .pld_oe_c, .pld_oe_d, .pld_out_a, .pld_out_b,
    .pld_out_c, .pld_out_d, .ecs_d, .imc_pt_clk_a, .imc_pt_clk_b,
    .imc_pt_clk_c, .pld_in_a, .pld_in_b, .pld_in_c, .pld_in_d,
    .periph_select_a, .periph_select_b, .jtag_pin_select, .jtag_enable,
    .jtag_o, .jtag_oe, .jtag_active, .jtag_i);
  pin_partner #(.W(8)) pa (.clk(clk), .o(pin_a_o), .oe(pin_a_oe),
    .ext_val(ext_a), .ext_en(en_a), .i(pin_a_i), .clash(clash[0]));
  pin_partner #(.W(8)) pb (.clk(clk), .o(pin_b_o), .oe(pin_b_oe),
    .ext_val(ext_b), .ext_en(en_b), .i(pin_b_i), .clash(clash[1]));
  pin_partner #(.W(8)) pc (.clk(clk), .o(pin_c_o), .oe(pin_c_oe),
    .ext_val(ext_c), .ext_en(en_c), .i(pin_c_i), .clash(clash[2]));
  pin_partner #(.W(3)) pd (.clk(clk), .o(pin_d_o), .oe(pin_d_oe),
    .ext_val(ext_d), .ext_en(en_d), .i(pin_d_i), .clash(clash[3]));

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [7:0] w);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000 fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    {rstn, reg_wr, reg_rd, strobe_pin, bus_read, bus_write, reg_addr} = 0;
    {reg_wdata, bus_dout, jtag_o, jtag_oe, pld_oe_a, pld_oe_b, pld_oe_c} = 0;
    {pld_out_a, pld_out_b, pld_out_c, pld_oe_d, pld_out_d, ecs_d} = 0;
    {host_addr, imc_pt_clk_a, imc_pt_clk_b, imc_pt_clk_c} = 0;
    {jtag_pin_select, jtag_enable, periph_select_a, periph_select_b} = 0;
    {ext_a, ext_b, ext_c, ext_d, en_a, en_b, en_c, en_d} = 0;
    {fail_count, cmp_count} = 0;
    seed = 32'h313c;
    cyc(6);
    rstn <= 1'b1;
    for (i = 0; i < 11; i = i + 1) rd(8'(i), 8'h00);
    chk(pin_a_oe | pin_b_oe | pin_c_oe, 8'h00);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'h00);
    for (i = 0; i < 10; i = i + 1) begin
      v = 8'($random(seed));
      wr(8'(i), v);
      rd(8'(i), (i == 5 || i == 9) ? v & 8'h07 : v);
    end
    wr(`OFS_CTRL_A, 8'h00);
    // first pass has no product term: direction bit alone
    for (i = 0; i < 4; i = i + 1) begin
      d = 8'($random(seed));
      q = 8'($random(seed));
      t = (i == 0) ? 8'h00 : 8'($random(seed));
      e = 8'($random(seed));
      wr(`OFS_DIR_A, d);
      wr(`OFS_DOUT_A, q);
      @(posedge clk);
      {pld_oe_a, pld_oe_c, ext_a, en_a} <= {t, t, e, ~(d | t)};
      {pld_out_a, pld_out_b, pld_out_c, jtag_o, jtag_oe} <= {5{e ^ q}};
      {pld_out_d, ecs_d, imc_pt_clk_a, imc_pt_clk_b} <= {e[5:0], q[1:0]};
      cyc(4);
      #1 chk(pin_a_oe, d | t);
      chk(pin_c_oe & t, t);
      chk(pin_a_o & (d | t), q & (d | t));
      chk(clash, 8'h00);
      rd(`OFS_ENOUT_A, d | t);
      rd(`OFS_DIN_A, (q & (d | t)) | (e & ~(d | t)));
    end
    wr(`OFS_DIR_D, 8'h05);
    wr(`OFS_DOUT_D, 8'h03);
    @(posedge clk) pld_oe_d <= 3'h2;
    cyc(3);
    #1 chk(pin_d_oe, 8'h07);
    chk(pin_d_o & 3'h5, 8'h01);
    v = 8'($random(seed));
    wr(`OFS_DIR_D, 8'h00);
    @(posedge clk) {pld_oe_d, ext_d, en_d} <= {3'h0, v[2:0], 3'h7};
    cyc(4);
    rd(`OFS_DIN_D, {5'h00, v[2:0]});
    chk(pld_in_d, {5'h00, v[2:0]});
    wr(`OFS_CTRL_B, 8'hFF);
    wr(`OFS_DIR_B, 8'h0F);
    @(posedge clk) {host_addr, strobe_pin, pld_oe_b} <= {16'hA5C3, 9'h130};
    {ext_b, en_b, pld_oe_d} <= {16'h80C0, 3'h0};
    cyc(5);
    strobe_pin <= 1'b0;
    cyc(5);
    host_addr <= 16'h5A3C;
    ext_b <= 8'h40;
    cyc(5);
    #1 chk(pin_b_oe, 8'h3F);
    chk(pin_b_o & 8'h3F, 8'h03);
    chk(pld_in_b, 8'h83);
    rd(`OFS_IMC_B, 8'h83);
    wr(`OFS_DIR_C, 8'h00);
    @(posedge clk) {pld_oe_c, ext_c, en_c} <= {16'h005A, 8'hFF};
    cyc(5);
    imc_pt_clk_c <= 1'b1;
    @(posedge clk) imc_pt_clk_c <= 1'b0;
    cyc(5);
    ext_c <= 8'hA5;
    cyc(5);
    #1 chk(pld_in_c, 8'h5A);
    rd(`OFS_IMC_C, 8'h5A);
    wr(`OFS_DIR_A, 8'hFF);
    @(posedge clk) {pld_oe_a, en_a} <= 16'h0000;
    wr(`OFS_MMAP, 8'h80);
    cyc(3);
    #1 chk(pin_a_oe, 8'h00);
    chk(bus_din, 8'h00);
    v = 8'($random(seed));
    @(posedge clk) {periph_select_a, bus_write, bus_dout} <= {2'h3, v};
    cyc(3);
    #1 chk(pin_a_oe, 8'hFF);
    chk(pin_a_o, v);
    chk(bus_din, 8'h00);
    @(posedge clk) {periph_select_a, periph_select_b} <= 2'h1;
    {bus_write, bus_read} <= 2'h1;
    cyc(2);
    {ext_a, en_a} <= 16'h69FF;
    cyc(5);
    #1 chk(pin_a_oe, 8'h00);
    chk(bus_din, 8'h69);
    chk(clash, 8'h00);
    @(posedge clk) {periph_select_b, bus_read, en_a} <= 10'h0;
    wr(`OFS_MMAP, 8'h00);
    cyc(2);
    #1 chk(pin_a_oe, 8'hFF);
    chk(jtag_i, 8'h05);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk) {jtag_pin_select, jtag_enable} <= {i == 1, i == 2};
      #1 chk(jtag_active, i != 0);
    end
    @(posedge clk) #1 chk(pin_c_oe, jtag_oe & 8'h0F);
    chk(pin_c_o & 8'h0F, jtag_o & 8'h0F);
    @(posedge clk) rstn <= 1'b0;
    cyc(2);
    #1 chk(pin_a_oe | pin_b_oe | pin_c_oe, 8'h00);
    @(posedge clk) rstn <= 1'b1;
    rd(`OFS_DIR_A, 8'h00);
    end_of_test;
  end
endmodule
